// ---- afe_housekeeping_pkg.sv ----
package afe_housekeeping_pkg;
    localparam logic [7:0] ADDR_GENERAL_RESET = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h09;
    localparam logic [7:0] ADDR_BIAS = 8'h10;
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h11;
    localparam logic [7:0] ADDR_PLL_LO = 8'h12;
    localparam logic [7:0] ADDR_PLL_HI = 8'h13;
    localparam logic [7:0] ADDR_CLOCK_STOP = 8'h14;
    localparam logic [7:0] ADDR_CLOCK_START = 8'h15;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h80;
    localparam logic [1:0] BIAS_RESET = 2'h0;
    localparam logic [15:0] CLOCK_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CLOCK_CONTROL_MASK = 16'h3fff;
    localparam logic [15:0] PLL_CFG_RESET = 16'h0000;
    localparam int ST_STARTUP = 7;
    localparam int ST_AUX_EOC = 6;
    localparam int ST_AUX_THR = 5;
    localparam int ST_CMP = 4;
    localparam int ST_SYNTH2 = 3;
    localparam int ST_SYNTH1 = 2;
    localparam int ST_RX = 1;
    localparam int ST_TX = 0;
    localparam int CC_STARTUP_EN = 13;
    localparam int CC_DELAY_LO = 8;
    localparam int CC_DIV_LO = 1;
    localparam int CC_AMP_EN = 0;
    localparam int BIAS_GEN_BIT = 1;
    localparam int BIAS_BUF_BIT = 0;
    localparam logic [4:0] ADDR_BIT_COUNT = 5'h08;
    localparam logic [4:0] WORD_BIT_COUNT = 5'h18;
    localparam logic [4:0] BIT_COUNT_MAX = 5'h1f;
    localparam logic [4:0] BYTE_BIT_COUNT = 5'h10;
    localparam logic [4:0] DELAY_MAX = 5'h14;

    typedef enum logic [3:0] {
        CLK_IDLE = 4'b0001,
        CLK_START = 4'b0010,
        CLK_RUN = 4'b0100,
        CLK_STOP = 4'b1000
    } clk_state_t;

    typedef struct packed {
        logic sclk_q;
        logic cs_n_q;
        logic [4:0] bit_cnt;
        logic [15:0] shift;
        logic [7:0] addr;
        logic addr_ok;
        logic [7:0] rd_shift;
        logic reply;
        logic gen_rst;
        logic core_rst;
        logic [7:0] status;
        logic [7:0] irq_en;
        logic irq_oe_n;
        logic [1:0] bias;
        logic [15:0] clk_ctl;
        logic [15:0] pll_lo;
        logic [15:0] pll_hi;
        clk_state_t clk_state;
        logic [6:0] div_cnt;
        logic [20:0] start_cnt;
        logic fwd_strobe;
        logic [7:0] fwd_addr;
        logic [15:0] fwd_data;
        logic fwd_wide;
    } hk_state_t;
endpackage

// ---- afe_housekeeping.sv ----
`timescale 1ns/10ps
module afe_housekeeping (
    // clock and resets
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic reset_pin_n_in,
    // serial control bus
    input wire logic sclk_in,
    input wire logic chip_select_n_in,
    input wire logic cmd_data_in,
    output logic reply_data_out,
    // status sources
    input wire logic aux_eoc_pulse_in,
    input wire logic [7:0] aux_adc_threshold_flags_in,
    input wire logic [4:0] comparator_flags_in,
    input wire logic [4:0] comparator_flag_enables_in,
    input wire logic [1:0] synth1_state_in,
    input wire logic [1:0] synth2_state_in,
    input wire logic [15:0] rx_flags_in,
    input wire logic [15:0] receive_flag_enables_in,
    input wire logic [7:0] tx_flags_in,
    input wire logic [7:0] transmit_flag_enables_in,
    // interrupt pin, open drain
    output logic irq_out_n_out,
    output logic irq_out_n_oe_n_out,
    // bias control
    output logic mid_rail_bias_en_out,
    output logic bias_buffer_en_out,
    // clock generator control
    output logic clk_gen_power_out,
    output logic sys_clk_enable_out,
    output logic mclk_amp_en_out,
    output logic [6:0] clk_divide_out,
    output logic [15:0] clock_pll_cfg_lo_out,
    output logic [15:0] clock_pll_cfg_hi_out,
    // internal reset and forwarded writes
    output logic core_reset_out,
    output logic fwd_write_strobe_out,
    output logic [7:0] fwd_write_addr_out,
    output logic [15:0] fwd_write_data_out,
    output logic fwd_write_wide_out
);
    // registered state and its next value
    afe_housekeeping_pkg::hk_state_t state_reg;
    afe_housekeeping_pkg::hk_state_t state_next;

    // bus edge events, one cycle wide
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic addr_done;
    logic [7:0] addr_now;
    // frame length seen at the closing select edge
    logic frame_cmd;
    logic frame_byte;
    logic frame_word;
    // device reset from pin or command
    logic dev_rst;
    logic clk_running;
    // status events
    logic read_clear;
    logic startup_set;
    logic eoc_set;
    logic div_pulse;

    // the three clock registers, writable only before the clock starts
    function automatic logic is_clock_reg(input logic [7:0] addr);
        return (addr == afe_housekeeping_pkg::ADDR_CLOCK_CONTROL) ||
            (addr == afe_housekeeping_pkg::ADDR_PLL_LO) ||
            (addr == afe_housekeeping_pkg::ADDR_PLL_HI);
    endfunction

    // addresses the bus may reach in the given clock state
    function automatic logic access_ok(
        input logic [7:0] addr,
        input afe_housekeeping_pkg::clk_state_t st
    );
        logic ok;
        ok = 1'b0;
        case (st)
            afe_housekeeping_pkg::CLK_IDLE,
            afe_housekeeping_pkg::CLK_START: begin
                ok = is_clock_reg(addr) ||
                    (addr == afe_housekeeping_pkg::ADDR_STATUS) ||
                    (addr == afe_housekeeping_pkg::ADDR_GENERAL_RESET);
            end
            afe_housekeeping_pkg::CLK_RUN: begin
                ok = 1'b1;
            end
            afe_housekeeping_pkg::CLK_STOP: begin
                ok = (addr == afe_housekeeping_pkg::ADDR_GENERAL_RESET) ||
                    (addr == afe_housekeeping_pkg::ADDR_CLOCK_START);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    // last divider count; a zero field wraps to a ratio of 128
    function automatic logic [6:0] div_last(input logic [6:0] field);
        return field - 7'h01;
    endfunction

    // startup end count, two to the field, illegal codes clipped
    function automatic logic [20:0] end_count(input logic [4:0] delay);
        logic [4:0] d;
        d = delay;
        if (d > afe_housekeeping_pkg::DELAY_MAX) begin
            d = afe_housekeeping_pkg::DELAY_MAX;
        end
        return 21'h000001 << d;
    endfunction

    // full reset image; select and serial clock idle high
    function automatic afe_housekeeping_pkg::hk_state_t reset_state();
        afe_housekeeping_pkg::hk_state_t s;
        s = '0;
        s.sclk_q = 1'b1;
        s.cs_n_q = 1'b1;
        s.status = afe_housekeeping_pkg::STATUS_RESET;
        s.irq_en = afe_housekeeping_pkg::IRQ_ENABLE_RESET;
        s.irq_oe_n = 1'b1;
        s.bias = afe_housekeeping_pkg::BIAS_RESET;
        s.clk_ctl = afe_housekeeping_pkg::CLOCK_CONTROL_RESET;
        s.pll_lo = afe_housekeeping_pkg::PLL_CFG_RESET;
        s.pll_hi = afe_housekeeping_pkg::PLL_CFG_RESET;
        s.clk_state = afe_housekeeping_pkg::CLK_IDLE;
        return s;
    endfunction

    always_comb begin
        state_next = state_reg;
        sclk_rise = sclk_in & ~state_reg.sclk_q;
        sclk_fall = ~sclk_in & state_reg.sclk_q;
        cs_fall = ~chip_select_n_in & state_reg.cs_n_q;
        cs_rise = chip_select_n_in & ~state_reg.cs_n_q;
        addr_done = sclk_rise && !chip_select_n_in &&
            (state_reg.bit_cnt == afe_housekeeping_pkg::ADDR_BIT_COUNT - 5'h01);
        addr_now = {state_reg.shift[6:0], cmd_data_in};
        frame_cmd = (state_reg.bit_cnt == afe_housekeeping_pkg::ADDR_BIT_COUNT);
        frame_byte = (state_reg.bit_cnt == afe_housekeeping_pkg::BYTE_BIT_COUNT);
        frame_word = (state_reg.bit_cnt == afe_housekeeping_pkg::WORD_BIT_COUNT);
        dev_rst = ~reset_pin_n_in | state_reg.gen_rst;
        clk_running = (state_reg.clk_state == afe_housekeeping_pkg::CLK_RUN);
        read_clear = 1'b0;
        startup_set = 1'b0;
        eoc_set = 1'b0;
        div_pulse = 1'b0;
        state_next.sclk_q = sclk_in;
        state_next.cs_n_q = chip_select_n_in;
        state_next.fwd_strobe = 1'b0;

        // serial shifter: address first, then data, msb first
        if (cs_fall) begin
            state_next.bit_cnt = 5'h00;
            state_next.shift = 16'h0000;
            state_next.addr_ok = 1'b0;
        end else if (sclk_rise && !chip_select_n_in) begin
            if (state_reg.bit_cnt != afe_housekeeping_pkg::BIT_COUNT_MAX) begin
                state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
            end
            if (addr_done) begin
                state_next.addr = addr_now;
                state_next.addr_ok = access_ok(addr_now, state_reg.clk_state);
                state_next.shift = 16'h0000;
            end else begin
                state_next.shift = {state_reg.shift[14:0], cmd_data_in};
            end
        end

        // status read: reply word loaded at the last address bit
        if (addr_done) begin
            if ((addr_now == afe_housekeeping_pkg::ADDR_STATUS) &&
                access_ok(addr_now, state_reg.clk_state)) begin
                state_next.rd_shift = state_reg.status;
                read_clear = 1'b1;
            end else begin
                state_next.rd_shift = 8'h00;
            end
        end
        if (sclk_fall && !chip_select_n_in) begin
            state_next.reply = state_reg.rd_shift[7];
            state_next.rd_shift = {state_reg.rd_shift[6:0], 1'b0};
        end

        // general reset held from the eighth rising edge to select release
        if (addr_done && (addr_now == afe_housekeeping_pkg::ADDR_GENERAL_RESET)) begin
            state_next.gen_rst = 1'b1;
        end
        if (cs_rise) begin
            state_next.gen_rst = 1'b0;
        end

        // startup timer counts divider output pulses
        case (state_reg.clk_state)
            afe_housekeeping_pkg::CLK_START: begin
                if (state_reg.div_cnt ==
                    div_last(state_reg.clk_ctl[afe_housekeeping_pkg::CC_DIV_LO +: 7])) begin
                    state_next.div_cnt = 7'h00;
                    div_pulse = 1'b1;
                end else begin
                    state_next.div_cnt = state_reg.div_cnt + 7'h01;
                end
                if (div_pulse) begin
                    if (state_reg.start_cnt + 21'h000001 ==
                        end_count(state_reg.clk_ctl[afe_housekeeping_pkg::CC_DELAY_LO +: 5])) begin
                        state_next.clk_state = afe_housekeeping_pkg::CLK_RUN;
                        startup_set =
                            state_reg.clk_ctl[afe_housekeeping_pkg::CC_STARTUP_EN];
                    end else begin
                        state_next.start_cnt = state_reg.start_cnt + 21'h000001;
                    end
                end
            end
            afe_housekeeping_pkg::CLK_IDLE,
            afe_housekeeping_pkg::CLK_RUN,
            afe_housekeeping_pkg::CLK_STOP: begin
                state_next.div_cnt = state_reg.div_cnt;
            end
            default: begin
                state_next.clk_state = afe_housekeeping_pkg::CLK_IDLE;
            end
        endcase

        // register writes and commands, taken at select release
        if (cs_rise && state_reg.addr_ok) begin
            case (state_reg.addr)
                afe_housekeeping_pkg::ADDR_IRQ_ENABLE: begin
                    if (frame_byte) begin
                        state_next.irq_en = state_reg.shift[7:0];
                    end
                end
                afe_housekeeping_pkg::ADDR_BIAS: begin
                    if (frame_byte) begin
                        state_next.bias = state_reg.shift[1:0];
                    end
                end
                afe_housekeeping_pkg::ADDR_CLOCK_CONTROL: begin
                    if (frame_word &&
                        state_reg.clk_state == afe_housekeeping_pkg::CLK_IDLE) begin
                        state_next.clk_ctl =
                            state_reg.shift & afe_housekeeping_pkg::CLOCK_CONTROL_MASK;
                        state_next.clk_state = afe_housekeeping_pkg::CLK_START;
                        state_next.div_cnt = 7'h00;
                        state_next.start_cnt = 21'h000000;
                    end
                end
                afe_housekeeping_pkg::ADDR_PLL_LO: begin
                    if (frame_word &&
                        state_reg.clk_state == afe_housekeeping_pkg::CLK_IDLE) begin
                        state_next.pll_lo = state_reg.shift;
                    end
                end
                afe_housekeeping_pkg::ADDR_PLL_HI: begin
                    if (frame_word &&
                        state_reg.clk_state == afe_housekeeping_pkg::CLK_IDLE) begin
                        state_next.pll_hi = state_reg.shift;
                    end
                end
                afe_housekeeping_pkg::ADDR_CLOCK_STOP: begin
                    if (frame_cmd && clk_running) begin
                        state_next.clk_state = afe_housekeeping_pkg::CLK_STOP;
                    end
                end
                afe_housekeeping_pkg::ADDR_CLOCK_START: begin
                    if (frame_cmd &&
                        state_reg.clk_state == afe_housekeeping_pkg::CLK_STOP) begin
                        state_next.clk_state = afe_housekeeping_pkg::CLK_RUN;
                    end
                end
                afe_housekeeping_pkg::ADDR_STATUS,
                afe_housekeeping_pkg::ADDR_GENERAL_RESET: begin
                    state_next.fwd_strobe = 1'b0;
                end
                default: begin
                    // other blocks only see traffic once the clock runs
                    if (clk_running && (frame_cmd || frame_byte || frame_word)) begin
                        state_next.fwd_strobe = 1'b1;
                        state_next.fwd_addr = state_reg.addr;
                        state_next.fwd_data = state_reg.shift;
                        state_next.fwd_wide = frame_word;
                    end
                end
            endcase
        end

        // level sources follow their flags only while the clock runs
        if (clk_running) begin
            eoc_set = aux_eoc_pulse_in;
            state_next.status[afe_housekeeping_pkg::ST_AUX_THR] =
                |aux_adc_threshold_flags_in;
            state_next.status[afe_housekeeping_pkg::ST_CMP] =
                |(comparator_flags_in & comparator_flag_enables_in);
            state_next.status[afe_housekeeping_pkg::ST_SYNTH2] = |synth2_state_in;
            state_next.status[afe_housekeeping_pkg::ST_SYNTH1] = |synth1_state_in;
            state_next.status[afe_housekeeping_pkg::ST_RX] =
                |(rx_flags_in & receive_flag_enables_in);
            state_next.status[afe_housekeeping_pkg::ST_TX] =
                |(tx_flags_in & transmit_flag_enables_in);
        end
        // sticky bits: a set in the read cycle wins over the clear
        state_next.status[afe_housekeeping_pkg::ST_STARTUP] =
            (state_reg.status[afe_housekeeping_pkg::ST_STARTUP] & ~read_clear) |
            startup_set;
        state_next.status[afe_housekeeping_pkg::ST_AUX_EOC] =
            (state_reg.status[afe_housekeeping_pkg::ST_AUX_EOC] & ~read_clear) |
            eoc_set;

        // pin or command reset: everything but the bus shifter, the general reset flag and the forwarded address, data and width
        if (dev_rst) begin
            state_next.status = afe_housekeeping_pkg::STATUS_RESET;
            state_next.irq_en = afe_housekeeping_pkg::IRQ_ENABLE_RESET;
            state_next.bias = afe_housekeeping_pkg::BIAS_RESET;
            state_next.clk_ctl = afe_housekeeping_pkg::CLOCK_CONTROL_RESET;
            state_next.pll_lo = afe_housekeeping_pkg::PLL_CFG_RESET;
            state_next.pll_hi = afe_housekeeping_pkg::PLL_CFG_RESET;
            state_next.clk_state = afe_housekeeping_pkg::CLK_IDLE;
            state_next.div_cnt = 7'h00;
            state_next.start_cnt = 21'h000000;
            state_next.fwd_strobe = 1'b0;
        end
        state_next.core_rst = ~reset_pin_n_in | state_next.gen_rst;
        // level interrupt, follows enables and sources both ways
        state_next.irq_oe_n = ~|(state_next.status & state_next.irq_en);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_reg <= reset_state();
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign reply_data_out = state_reg.reply;
    assign irq_out_n_out = state_reg.irq_oe_n;
    assign irq_out_n_oe_n_out = state_reg.irq_oe_n;
    assign mid_rail_bias_en_out = state_reg.bias[afe_housekeeping_pkg::BIAS_GEN_BIT];
    assign bias_buffer_en_out = state_reg.bias[afe_housekeeping_pkg::BIAS_BUF_BIT];
    assign clk_gen_power_out = (state_reg.clk_state != afe_housekeeping_pkg::CLK_IDLE);
    assign sys_clk_enable_out = (state_reg.clk_state == afe_housekeeping_pkg::CLK_RUN);
    assign mclk_amp_en_out = state_reg.clk_ctl[afe_housekeeping_pkg::CC_AMP_EN];
    assign clk_divide_out = state_reg.clk_ctl[afe_housekeeping_pkg::CC_DIV_LO +: 7];
    assign clock_pll_cfg_lo_out = state_reg.pll_lo;
    assign clock_pll_cfg_hi_out = state_reg.pll_hi;
    assign core_reset_out = state_reg.core_rst;
    assign fwd_write_strobe_out = state_reg.fwd_strobe;
    assign fwd_write_addr_out = state_reg.fwd_addr;
    assign fwd_write_data_out = state_reg.fwd_data;
    assign fwd_write_wide_out = state_reg.fwd_wide;

    irq_level_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_reg.irq_oe_n == !(|(state_reg.status & state_reg.irq_en)))
        else $error("interrupt pin disagrees with enabled status bits");

    enable_reset_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $past(sys_rst_in) |->
        (state_reg.irq_en == afe_housekeeping_pkg::IRQ_ENABLE_RESET) &&
        (state_reg.status == afe_housekeeping_pkg::STATUS_RESET))
        else $error("enable or status register wrong after reset");

    quiet_gate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_reg.fwd_strobe |->
        $past(state_reg.clk_state) == afe_housekeeping_pkg::CLK_RUN)
        else $error("write forwarded while system clock not running");

    clock_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg.clk_state != afe_housekeeping_pkg::CLK_IDLE) &&
        ($past(state_reg.clk_state) != afe_housekeeping_pkg::CLK_IDLE) |->
        $stable(state_reg.clk_ctl) && $stable(state_reg.pll_lo) && $stable(state_reg.pll_hi))
        else $error("clock registers changed after clock control write");

    gen_reset_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $past(state_reg.gen_rst) |->
        (state_reg.clk_state == afe_housekeeping_pkg::CLK_IDLE) &&
        (state_reg.irq_en == afe_housekeeping_pkg::IRQ_ENABLE_RESET))
        else $error("command reset did not return device to reset state");

    startup_done_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg.clk_state == afe_housekeeping_pkg::CLK_RUN) &&
        ($past(state_reg.clk_state) == afe_housekeeping_pkg::CLK_START) &&
        state_reg.clk_ctl[afe_housekeeping_pkg::CC_STARTUP_EN] |->
        state_reg.status[afe_housekeeping_pkg::ST_STARTUP])
        else $error("startup done bit missing at end of startup count");

    core_reset_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_reg.gen_rst |-> state_reg.core_rst)
        else $error("internal reset not driven during command reset");

    stop_gate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg.clk_state == afe_housekeeping_pkg::CLK_STOP) |-> !state_reg.fwd_strobe)
        else $error("write forwarded while system clock stopped");
endmodule

// ---- host_model.sv ----
`timescale 1ns/10ps
module host_model (
    input wire logic clk_in,
    output logic sclk_out = 1'b1,
    output logic cs_n_out = 1'b1,
    output logic mosi_out = 1'b0,
    input wire logic miso_in
);
    // address then data, msb first; clock idles high between frames
    task automatic xfer(input logic [23:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        @(negedge clk_in) cs_n_out = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            repeat (4) @(negedge clk_in);
            sclk_out = 1'b0;
            mosi_out = w[i];
            repeat (4) @(negedge clk_in);
            sclk_out = 1'b1;
            r = {r[14:0], miso_in};
        end
        repeat (4) @(negedge clk_in);
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        repeat (8) @(negedge clk_in);
    endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [15:0] s = 16'h0000;
    logic [15:0] r;
    logic sck, chip_select_n, mo, mi, oen, vb, bb, ce, ip;
    int mismatches = 0;
    int checks = 0;
    always #2 clk_in = ~clk_in;
    host_model host_u (.clk_in, .sclk_out(sck), .cs_n_out(chip_select_n), .mosi_out(mo), .miso_in(mi));
    afe_housekeeping dut_u (.clk_in, .sys_rst_in, .reset_pin_n_in(1'b1), .sclk_in(sck),
        .chip_select_n_in(chip_select_n), .cmd_data_in(mo), .reply_data_out(mi), .aux_eoc_pulse_in(s[0]),
        .aux_adc_threshold_flags_in(s[7:0]), .comparator_flags_in(s[4:0]),
        .comparator_flag_enables_in(s[4:0]), .synth1_state_in(s[1:0]),
        .synth2_state_in(s[1:0]), .rx_flags_in(s), .receive_flag_enables_in(s),
        .tx_flags_in(s[7:0]), .transmit_flag_enables_in(s[7:0]), .irq_out_n_out(ip),
        .irq_out_n_oe_n_out(oen), .mid_rail_bias_en_out(vb), .bias_buffer_en_out(bb),
        .clk_gen_power_out(), .sys_clk_enable_out(ce), .mclk_amp_en_out(), .clk_divide_out(),
        .clock_pll_cfg_lo_out(), .clock_pll_cfg_hi_out(), .core_reset_out(),
        .fwd_write_strobe_out(), .fwd_write_addr_out(), .fwd_write_data_out(),
        .fwd_write_wide_out());
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk_in);
        sys_rst_in = 1'b0;
        host_u.xfer(24'h100300, 16, r);
        chk("bias", 16'h0, {vb, bb});
        host_u.xfer(24'h120000, 24, r);
        host_u.xfer(24'h130000, 24, r);
        host_u.xfer(24'h112002, 24, r);
        for (int n = 0; n < 500 && ce !== 1'b1; n++) @(negedge clk_in);
        chk("clk", 16'h1, ce);
        chk("irq", 16'h0, oen);
        chk("irqpin", 16'h0, ip);
        host_u.xfer(24'h080000, 16, r);
        chk("stat", 16'h80, r[7:0]);
        chk("irq", 16'h1, oen);
        host_u.xfer(24'h100300, 16, r);
        chk("bias", 16'h3, {vb, bb});
        s = 16'h0001;
        host_u.xfer(24'h090200, 16, r);
        chk("irq", 16'h0, oen);
        host_u.xfer(24'h140000, 8, r);
        chk("clk", 16'h0, ce);
        host_u.xfer(24'h150000, 8, r);
        chk("clk", 16'h1, ce);
        host_u.xfer(24'h010000, 8, r);
        chk("clk", 16'h0, ce);
        stop_test();
    end
endmodule
